// file: hw/cbl_config_loader.sv
// Purpose: Option bytes, live copies, chip lock and programming link.
// Assumes: Flash array answers a read one cycle after its request.
// Notes: Option storage and link logic survive every reset but power-on.
`timescale 1ns/1ps
`include "cbl_defs.svh"
module cbl_config_loader #(
	parameter int FLASH_KB = `CBL_FLASH_KB
) (
	// Clock and resets.
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic por_n,
	input wire logic last_reset_sw,
	// Shared reset pin.
	input wire logic reset_pin_in,
	// Programming link pins.
	input wire logic prog_clock_pin,
	input wire logic prog_data_in,
	output logic prog_data_out,
	output logic prog_data_oe_n,
	// Flash array port.
	output cbl_pkg::cbl_flash_type flash_cmd,
	output logic flash_erase_all,
	input wire logic [7:0] flash_rdata,
	// In-application writes of the option bytes.
	input wire logic iap_opt_wr,
	input wire logic iap_opt_sel,
	input wire logic [7:0] iap_opt_wdata,
	// Software access to the live copies.
	input wire logic sw_live_wr,
	input wire cbl_pkg::cbl_live_type sw_live_data,
	output cbl_pkg::cbl_live_type live,
	// Decoded controls.
	output logic boot_from_app,
	output logic debug_unit_en,
	output logic reset_pin_is_reset,
	output logic ext_reset_req,
	output logic chip_locked,
	output logic in_circuit_programming,
	output logic [2:0] loader_kbytes,
	output logic [4:0] app_kbytes
);

	// Refuse a flash size the five-bit app_kbytes output cannot carry.
	if (FLASH_KB < 4 || FLASH_KB > 31)
	begin : g_bad_size
		$error("FLASH_KB must lie between 4 and 31.");
	end

	// Two-stage synchronisers and the previous link clock level.
	logic [1:0] rst_pin_sync;
	logic [1:0] clk_pin_sync;
	logic [1:0] dat_pin_sync;
	logic clk_pin_prev;
	logic clk_rise;
	// Nonvolatile option bytes.
	cbl_pkg::cbl_opt0_type opt0;
	logic [7:0] opt1;
	// Frame engine state.
	cbl_pkg::cbl_icp_state_type icp_state;
	logic [4:0] bit_cnt;
	logic [25:0] shift_in;
	logic [7:0] shift_out;
	logic hdr_done;
	logic frame_done;
	logic rd_capture;
	// Copy request, high during reset and for one cycle after release.
	logic load_pend;
	// Command of the frame just finished.
	logic [2:0] fr_cmd;
	logic [2:0] hd_cmd;
	logic opt_prog_ok;
	logic erase_now;

	assign clk_rise = clk_pin_sync[1] & ~clk_pin_prev;
	assign fr_cmd = shift_in[`CBL_FR_CMD];
	assign hd_cmd = shift_in[`CBL_HD_CMD];
	// Option bytes may be programmed singly only while unlocked.
	assign opt_prog_ok = frame_done & (fr_cmd == `CBL_CMD_PR_OPT) & opt0.chip_unlocked; // R5
	assign erase_now = frame_done & (fr_cmd == `CBL_CMD_ERASE_ALL);

	// Pins from outside pass two flip-flops before any logic reads them.
	always_ff @(posedge clk_sys or negedge por_n)
	begin
		if (!por_n)
		begin
			rst_pin_sync <= 2'h3;
			clk_pin_sync <= 2'h0;
			dat_pin_sync <= 2'h3;
			clk_pin_prev <= 1'b0;
		end
		else
		begin
			rst_pin_sync <= {rst_pin_sync[0], reset_pin_in};
			clk_pin_sync <= {clk_pin_sync[0], prog_clock_pin};
			dat_pin_sync <= {dat_pin_sync[0], prog_data_in};
			clk_pin_prev <= clk_pin_sync[1];
		end
	end

	// Reset pin low holds the link in programming mode.
	always_ff @(posedge clk_sys or negedge por_n)
	begin
		if (!por_n)
		begin
			in_circuit_programming <= 1'b0;
			ext_reset_req <= 1'b0;
		end
		else
		begin
			in_circuit_programming <= ~rst_pin_sync[1]; // R10
			// A plain input pin never asks for a reset.
			ext_reset_req <= live.reset_pin_keep & ~rst_pin_sync[1]; // R3
		end
	end

	// Frame engine: bits enter on each rising link clock edge.
	always_ff @(posedge clk_sys or negedge por_n)
	begin
		if (!por_n)
		begin
			icp_state <= cbl_pkg::CBL_HEADER;
			bit_cnt <= 5'h00;
			shift_in <= 26'h000_0000;
		end
		else if (!in_circuit_programming)
		begin
			// Leaving the mode drops any half frame.
			icp_state <= cbl_pkg::CBL_HEADER;
			bit_cnt <= 5'h00;
		end
		else if (clk_rise)
		begin
			shift_in <= {shift_in[24:0], dat_pin_sync[1]}; // R11
			bit_cnt <= bit_cnt + 5'h01;
			unique case (icp_state)
				cbl_pkg::CBL_HEADER:
				begin
					// The header's command sits one bit short of its place.
					if (bit_cnt == `CBL_HDR_LAST)
					begin
						if (shift_in[16:15] == 2'h0)
							icp_state <= cbl_pkg::CBL_READ;
						else
							icp_state <= cbl_pkg::CBL_WRITE;
					end
				end
				cbl_pkg::CBL_READ,
				cbl_pkg::CBL_WRITE:
				begin
					if (bit_cnt == `CBL_FRAME_LAST)
					begin
						icp_state <= cbl_pkg::CBL_HEADER;
						bit_cnt <= 5'h00;
					end
				end
				default:
				begin
					icp_state <= cbl_pkg::CBL_HEADER;
					bit_cnt <= 5'h00;
				end
			endcase
		end
	end

	// One-cycle marks for a finished header and a finished write frame.
	always_ff @(posedge clk_sys or negedge por_n)
	begin
		if (!por_n)
		begin
			hdr_done <= 1'b0;
			frame_done <= 1'b0;
			rd_capture <= 1'b0;
		end
		else
		begin
			hdr_done <= in_circuit_programming & clk_rise & (bit_cnt == `CBL_HDR_LAST)
				& (icp_state == cbl_pkg::CBL_HEADER);
			frame_done <= in_circuit_programming & clk_rise & (bit_cnt == `CBL_FRAME_LAST)
				& (icp_state == cbl_pkg::CBL_WRITE);
			rd_capture <= flash_cmd.req & ~flash_cmd.we;
		end
	end

	// Flash requests; programming is dropped while locked.
	always_ff @(posedge clk_sys or negedge por_n)
	begin
		if (!por_n)
		begin
			flash_cmd <= '0;
			flash_erase_all <= 1'b0;
		end
		else
		begin
			flash_cmd <= '0;
			flash_erase_all <= erase_now; // R5
			if (hdr_done && hd_cmd == `CBL_CMD_RD_FLASH)
			begin
				flash_cmd.req <= 1'b1;
				flash_cmd.addr <= shift_in[`CBL_HD_ADDR];
			end
			else if (frame_done && fr_cmd == `CBL_CMD_PR_FLASH && opt0.chip_unlocked) // R4
			begin
				flash_cmd.req <= 1'b1;
				flash_cmd.we <= 1'b1;
				flash_cmd.addr <= shift_in[`CBL_FR_ADDR];
				flash_cmd.wdata <= shift_in[`CBL_FR_DATA];
			end
		end
	end

	// Read data goes out MSB first, one bit per rising link edge.
	always_ff @(posedge clk_sys or negedge por_n)
	begin
		if (!por_n)
		begin
			shift_out <= `CBL_BLANK;
			prog_data_out <= 1'b1;
			prog_data_oe_n <= 1'b1;
		end
		else
		begin
			if (rd_capture)
				// A locked chip shows only blank bytes.
				shift_out <= opt0.chip_unlocked ? flash_rdata : `CBL_BLANK; // R4
			else if (hdr_done && hd_cmd == `CBL_CMD_RD_OPT)
				// Option bytes stay readable whatever the lock.
				shift_out <= shift_in[0] ? opt1 : opt0; // R5
			else if (clk_rise && icp_state == cbl_pkg::CBL_READ)
				shift_out <= {shift_out[6:0], 1'b1}; // R11
			prog_data_out <= shift_out[7];
			prog_data_oe_n <= ~(in_circuit_programming && icp_state == cbl_pkg::CBL_READ);
		end
	end

	// Option storage; erased bits read one and select defaults.
	always_ff @(posedge clk_sys or negedge por_n)
	begin
		if (!por_n)
		begin
			opt0 <= `CBL_ERASED; // R14
			opt1 <= `CBL_ERASED; // R12
		end
		else if (erase_now)
		begin
			// Whole erase is the one link command out of the lock; writes from code on the chip can also unlock.
			opt0 <= `CBL_ERASED; // R5
			opt1 <= `CBL_ERASED;
		end
		else if (opt_prog_ok)
		begin
			// Reserved bits are kept unprogrammed whatever arrives.
			if (shift_in[8])
				opt1 <= shift_in[`CBL_FR_DATA] | `CBL_OPT1_RSV; // R9
			else
				opt0 <= shift_in[`CBL_FR_DATA] | `CBL_OPT0_RSV; // R9
		end
		else if (iap_opt_wr)
		begin
			// Code on the chip writes options even when locked.
			if (iap_opt_sel)
				opt1 <= iap_opt_wdata | `CBL_OPT1_RSV; // R6
			else
				opt0 <= iap_opt_wdata | `CBL_OPT0_RSV; // R6
		end
	end

	// Copy request follows the system reset.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			load_pend <= 1'b1;
		else
			load_pend <= 1'b0;
	end

	// Live copies load after reset, then software owns them.
	always_ff @(posedge clk_sys or negedge por_n)
	begin
		if (!por_n)
			live <= `CBL_LIVE_ERASED;
		else if (load_pend)
		begin
			// A software reset leaves the boot choice as it was.
			if (!last_reset_sw)
				live.boot_source_select <= opt0.boot_source_select; // R1
			live.debugger_enable_n <= opt0.debugger_enable_n; // R8
			live.reset_pin_keep <= opt0.reset_pin_keep; // R8
			live.loader_area_size <= opt1[2:0]; // R8
		end
		else if (sw_live_wr)
			live <= sw_live_data; // R8
	end

	// Loader kilobytes for a size code; codes below four all give the largest loader.
	function automatic logic [2:0] loader_kb_of(input logic [2:0] code);
		if (!code[2])
			return `CBL_KB_4;
		return `CBL_LD_NONE - code;
	endfunction

	// Decoded controls from the live copies; the lock state comes straight from opt0.
	always_ff @(posedge clk_sys or negedge por_n)
	begin
		if (!por_n)
		begin
			boot_from_app <= 1'b1;
			debug_unit_en <= 1'b0;
			reset_pin_is_reset <= 1'b1;
			chip_locked <= 1'b0;
			loader_kbytes <= `CBL_KB_0;
			app_kbytes <= 5'(FLASH_KB);
		end
		else
		begin
			boot_from_app <= live.boot_source_select; // R1
			// Enable is low active and the lock overrides it.
			debug_unit_en <= ~live.debugger_enable_n & opt0.chip_unlocked; // R2 R13
			reset_pin_is_reset <= live.reset_pin_keep; // R3
			chip_locked <= ~opt0.chip_unlocked;
			unique casez (live.loader_area_size)
				`CBL_LD_NONE: loader_kbytes <= `CBL_KB_0; // R7
				`CBL_LD_1K: loader_kbytes <= `CBL_KB_1;
				`CBL_LD_2K: loader_kbytes <= `CBL_KB_2;
				`CBL_LD_3K: loader_kbytes <= `CBL_KB_3;
				3'b0??: loader_kbytes <= `CBL_KB_4;
			endcase
			app_kbytes <= 5'(FLASH_KB) - {2'h0, loader_kb_of(live.loader_area_size)}; // R7
		end
	end

	// Locked reads of flash give blank bytes.
	lock_read_a: assert property (@(posedge clk_sys) disable iff (!por_n) // R4
		rd_capture && !opt0.chip_unlocked |=> shift_out == `CBL_BLANK)
		else $error("Locked flash read did not return blank.");

	// No flash write leaves while locked.
	lock_prog_a: assert property (@(posedge clk_sys) disable iff (!por_n) // R4
		flash_cmd.we |-> $past(opt0.chip_unlocked))
		else $error("Flash written while locked.");

	// Locked options ignore single programming.
	opt_lock_a: assert property (@(posedge clk_sys) disable iff (!por_n) // R5
		frame_done && fr_cmd == `CBL_CMD_PR_OPT && !opt0.chip_unlocked && !iap_opt_wr
		|=> $stable(opt0) && $stable(opt1))
		else $error("Locked option byte changed.");

	// In-application writes act when locked too.
	iap_write_a: assert property (@(posedge clk_sys) disable iff (!por_n) // R6
		iap_opt_wr && !iap_opt_sel && !erase_now && !opt_prog_ok
		|=> opt0 == ($past(iap_opt_wdata) | `CBL_OPT0_RSV))
		else $error("In-application option write lost.");

	// Debug unit off whenever locked.
	debug_gate_a: assert property (@(posedge clk_sys) disable iff (!por_n) // R13
		debug_unit_en |-> !$past(live.debugger_enable_n) && $past(opt0.chip_unlocked))
		else $error("Debug unit enabled against its bits.");

	// Loader and application share the whole flash.
	size_split_a: assert property (@(posedge clk_sys) disable iff (!por_n) // R7
		5'(loader_kbytes) + app_kbytes == 5'(FLASH_KB))
		else $error("Flash split does not add up.");

	// Boot choice follows the option after a hardware reset.
	boot_load_a: assert property (@(posedge clk_sys) disable iff (!por_n) // R1
		load_pend && !last_reset_sw && rst_n |=> ##1
		boot_from_app == $past(opt0.boot_source_select, 2))
		else $error("Boot source not loaded.");

	// Software writes reach the live copies.
	live_write_a: assert property (@(posedge clk_sys) disable iff (!por_n || !rst_n) // R8
		sw_live_wr && !load_pend |=> live == $past(sw_live_data))
		else $error("Live copy write lost.");

	// Data pin driven only inside programming mode.
	link_drive_a: assert property (@(posedge clk_sys) disable iff (!por_n) // R10
		!prog_data_oe_n |-> $past(in_circuit_programming))
		else $error("Data pin driven outside programming.");

	// Reset requests come only from a reset-function pin.
	pin_reset_a: assert property (@(posedge clk_sys) disable iff (!por_n) // R3
		ext_reset_req |-> $past(live.reset_pin_keep) && !$past(rst_pin_sync[1]))
		else $error("Reset raised by a plain input pin.");

endmodule // cbl_config_loader

// file: hw/cbl_defs.svh
// Purpose: Constants of the option byte loader and lock block.
// Assumes: Included by its bare name from hw/.
// Notes: Types live in cbl_pkg.
// What this block does
// R1 - Boot bit picks application or loader flash
// R2 - Debugger enable bit is active low
// R3 - Keep bit makes shared pin a reset
// R4 - Locked chip reads blank, ignores programming
// R5 - Options readable; locked only whole erase clears
// R6 - Lock never restricts in-application programming
// R7 - Loader size field splits eighteen kilobyte flash
// R8 - Option bits copied to live copies after reset
// R9 - Programmer leaves reserved option bits unprogrammed
// R10 - Reset pin low enters in-circuit programming
// R11 - Data pin shifts in step with link clock
// R12 - Loader size byte ships as all ones
// R13 - Debug unit dead while chip is locked
// R14 - Erased option bit reads one, selects default
`ifndef CBL_DEFS_SVH
`define CBL_DEFS_SVH
// Erased value of an option byte and of a blank flash byte.
`define CBL_ERASED 8'hFF
`define CBL_BLANK 8'hFF
// Reserved bits of each option byte, held at one.
`define CBL_OPT0_RSV 8'h69
`define CBL_OPT1_RSV 8'hF8
// Live copies after power-on, every field erased.
`define CBL_LIVE_ERASED 6'h3F
// Flash size in kilobytes.
`define CBL_FLASH_KB 18
// Loader size codes and the kilobytes they give.
`define CBL_LD_NONE 3'h7
`define CBL_LD_1K 3'h6
`define CBL_LD_2K 3'h5
`define CBL_LD_3K 3'h4
`define CBL_KB_0 3'h0
`define CBL_KB_1 3'h1
`define CBL_KB_2 3'h2
`define CBL_KB_3 3'h3
`define CBL_KB_4 3'h4
// Frame layout: 3 command bits, 15 address bits, 8 data bits.
`define CBL_HDR_LAST 5'h11
`define CBL_FRAME_LAST 5'h19
`define CBL_HD_CMD 17:15
`define CBL_HD_ADDR 14:0
`define CBL_FR_CMD 25:23
`define CBL_FR_ADDR 22:8
`define CBL_FR_DATA 7:0
// Link commands.
`define CBL_CMD_RD_FLASH 3'h0
`define CBL_CMD_RD_OPT 3'h1
`define CBL_CMD_PR_FLASH 3'h2
`define CBL_CMD_PR_OPT 3'h3
`define CBL_CMD_ERASE_ALL 3'h4
`endif

// file: hw/cbl_pkg.sv
// Purpose: Types of the option byte loader and lock block.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Constants sit in cbl_defs.svh.
package cbl_pkg;
	// First option byte, bit 7 down to bit 0.
	typedef struct packed
	{
		logic boot_source_select;
		logic [1:0] rsv_hi;
		logic debugger_enable_n;
		logic rsv_mid;
		logic reset_pin_keep;
		logic chip_unlocked;
		logic rsv_lo;
	} cbl_opt0_type;
	// Live copies that software may change.
	typedef struct packed
	{
		logic boot_source_select;
		logic debugger_enable_n;
		logic reset_pin_keep;
		logic [2:0] loader_area_size;
	} cbl_live_type;
	// One request to the flash array.
	typedef struct packed
	{
		logic req;
		logic we;
		logic [14:0] addr;
		logic [7:0] wdata;
	} cbl_flash_type;
	// Phase of a programming link frame.
	typedef enum logic [1:0]
	{
		CBL_HEADER = 2'b00,
		CBL_READ = 2'b01,
		CBL_WRITE = 2'b10
	} cbl_icp_state_type;
endpackage

// file: verification/cbl_prog_model.sv
// Purpose: Programmer on the far side of the two-wire programming link.
// Assumes: Link period 48 ns; clock stands low outside frames.
// Notes: The bench resolves the shared data wire and feeds it back here.
`timescale 1ns/1ps
module cbl_prog_model (
	// Pins driven by the programmer.
	output logic prog_clock_pin,
	output logic prog_data_drv,
	output logic reset_pin,
	// Level seen on the shared data wire.
	input wire logic prog_wire
);
	// Idle pins: clock still, data high, reset pin released.
	initial
	begin
		prog_clock_pin = 1'b0;
		prog_data_drv = 1'b1;
		reset_pin = 1'b1;
	end
	// A low reset pin asks for programming mode, a high one ends it.
	task automatic set_mode(input logic on);
		reset_pin = !on;
	endtask
	// Shifts one frame MSB first; answer bits are taken at edges 19 to 26.
	task automatic frame(input logic [25:0] bits, output logic [7:0] rd);
		int i;
		for (i = 25; i >= 0; i--)
		begin
			#12;
			prog_data_drv = bits[i];
			#12;
			if (i < 8)
			begin
				rd[i] = prog_wire;
			end
			prog_clock_pin = 1'b1;
			#24;
			prog_clock_pin = 1'b0;
		end
		// A stale level must not look like a valid answer afterwards.
		prog_data_drv = !prog_data_drv;
	endtask
endmodule // cbl_prog_model

// file: verification/tb_top.sv
// Purpose: Self-checking bench of the option byte loader and lock block.
// Assumes: Flash answers one cycle after a read request.
// Notes: Option byte cases run from a table; link cases are written out.
`timescale 1ns/1ps
`include "cbl_defs.svh"
`define CHK(g, e) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); \
		end \
	end
module tb_top;
	// Option bytes, reset kind and expected {boot,dbg,pin,lock,loader,app}.
	typedef struct packed
	{
		logic [7:0] opt0;
		logic [7:0] opt1;
		logic sw;
		logic [11:0] exp;
	} cbl_row_type;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic por_n = 1'b0;
	logic last_reset_sw = 1'b0;
	logic reset_pin, pclk, pdrv, pwire, dout, oe_n, erase;
	logic iap_opt_wr = 1'b0;
	logic iap_opt_sel = 1'b0;
	logic [7:0] iap_opt_wdata = 8'h00;
	logic [7:0] flash_rdata = 8'h00;
	logic sw_live_wr = 1'b0;
	cbl_pkg::cbl_live_type sw_live_data = 6'h00;
	cbl_pkg::cbl_live_type live;
	cbl_pkg::cbl_flash_type flash_cmd;
	logic boot_from_app, debug_unit_en, reset_pin_is_reset, ext_reset_req;
	logic chip_locked, in_circuit_programming;
	logic [2:0] loader_kbytes;
	logic [4:0] app_kbytes;
	int error_cnt = 0;
	int total_checks = 0;
	int wr_cnt = 0;
	int erase_cnt = 0;
	logic [22:0] wr_last;
	logic [7:0] rd;
	// Reserved bits of every row stay one; opt1 0x00 shows the forcing.
	cbl_row_type rows [6] = '{
		'{8'hFF, 8'hFF, 1'b0, 12'hA12},
		'{8'h6F, 8'hFE, 1'b0, 12'h631},
		'{8'hE9, 8'hFD, 1'b0, 12'h950},
		'{8'hFF, 8'hFC, 1'b0, 12'hA6F},
		'{8'h7F, 8'h00, 1'b1, 12'hA8E},
		'{8'h7F, 8'hFB, 1'b0, 12'h28E}};
	// System clock, 200 MHz.
	always #2.5 clk_sys = !clk_sys;
	// The device drives the data wire only while its enable is low.
	assign pwire = (oe_n === 1'b0) ? dout : pdrv;
	// Flash stand-in: data one cycle after a read, counts of writes and erases.
	always @(posedge clk_sys)
	begin
		flash_rdata <= flash_cmd.req ? (flash_cmd.addr[7:0] ^ 8'h5A) : ~flash_rdata;
		if (flash_cmd.req && flash_cmd.we)
		begin
			wr_cnt <= wr_cnt + 1;
			wr_last <= {flash_cmd.addr, flash_cmd.wdata};
		end
		if (erase)
			erase_cnt <= erase_cnt + 1;
	end
	cbl_config_loader i_cbl_config_loader (.clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n),
		.last_reset_sw(last_reset_sw), .reset_pin_in(reset_pin), .prog_clock_pin(pclk),
		.prog_data_in(pwire), .prog_data_out(dout), .prog_data_oe_n(oe_n),
		.flash_cmd(flash_cmd), .flash_erase_all(erase), .flash_rdata(flash_rdata),
		.iap_opt_wr(iap_opt_wr), .iap_opt_sel(iap_opt_sel), .iap_opt_wdata(iap_opt_wdata),
		.sw_live_wr(sw_live_wr), .sw_live_data(sw_live_data), .live(live),
		.boot_from_app(boot_from_app), .debug_unit_en(debug_unit_en),
		.reset_pin_is_reset(reset_pin_is_reset), .ext_reset_req(ext_reset_req),
		.chip_locked(chip_locked), .in_circuit_programming(in_circuit_programming),
		.loader_kbytes(loader_kbytes), .app_kbytes(app_kbytes));
	cbl_prog_model i_cbl_prog_model (.prog_clock_pin(pclk), .prog_data_drv(pdrv),
		.reset_pin(reset_pin), .prog_wire(pwire));
	// Writes one option byte from application code.
	task automatic in_app_programming(input logic sel, input logic [7:0] val);
		@(posedge clk_sys);
		iap_opt_wr <= 1'b1;
		iap_opt_sel <= sel;
		iap_opt_wdata <= val;
		@(posedge clk_sys);
		iap_opt_wr <= 1'b0;
	endtask
	// System reset; the kind flag is held until the reload is over.
	task automatic sys_reset(input logic sw);
		@(posedge clk_sys);
		last_reset_sw <= sw;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		last_reset_sw <= 1'b0;
		#1;
	endtask
	// One link frame; answers of read commands are compared.
	task automatic lk(input logic [2:0] c, input logic [14:0] a, input logic [7:0] d,
		input logic [7:0] e);
		i_cbl_prog_model.frame({c, a, d}, rd);
		repeat (4) @(posedge clk_sys);
		#1;
		if (c <= `CBL_CMD_RD_OPT)
			`CHK(rd, e)
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// The whole run takes some 15 us; a hang is cut off well after that.
	initial
	begin
		#300000;
		error_cnt++;
		tally_and_finish();
	end
	// Main sequence.
	initial
	begin
		repeat (16) @(posedge clk_sys);
		por_n <= 1'b1;
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		// Rows: option writes from code, then a reset reloads the live copies.
		foreach (rows[i])
		begin
			in_app_programming(1'b0, rows[i].opt0);
			in_app_programming(1'b1, rows[i].opt1);
			sys_reset(rows[i].sw);
			`CHK({boot_from_app, debug_unit_en, reset_pin_is_reset, chip_locked, loader_kbytes, app_kbytes}, rows[i].exp)
		end
		$display("Test option table done");
		// Software changes the live copies after the reload.
		@(posedge clk_sys);
		sw_live_wr <= 1'b1;
		sw_live_data <= 6'h25;
		@(posedge clk_sys);
		sw_live_wr <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK(live, 6'h25)
		`CHK({boot_from_app, debug_unit_en, loader_kbytes, app_kbytes}, 10'h350)
		$display("Test software copies done");
		// Power-on: every option erased, default behaviour everywhere.
		@(posedge clk_sys);
		por_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		por_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		`CHK({boot_from_app, debug_unit_en, reset_pin_is_reset, chip_locked, loader_kbytes, app_kbytes}, 12'hA12)
		`CHK({live, oe_n}, 7'h7F)
		$display("Test power-on done");
		// Programming link: mode entry, reads, writes, lock and whole erase.
		i_cbl_prog_model.set_mode(1'b1);
		repeat (8) @(posedge clk_sys);
		#1;
		`CHK({in_circuit_programming, ext_reset_req}, 2'b11)
		lk(`CBL_CMD_RD_OPT, 15'h0001, 8'h00, 8'hFF);
		lk(`CBL_CMD_RD_FLASH, 15'h0123, 8'h00, 8'h79);
		lk(`CBL_CMD_PR_FLASH, 15'h0042, 8'hA5, 8'h00);
		`CHK({wr_cnt[3:0], wr_last}, 27'h080_42A5)
		lk(`CBL_CMD_PR_OPT, 15'h0000, 8'hE9, 8'h00);
		lk(`CBL_CMD_RD_OPT, 15'h0000, 8'h00, 8'hE9);
		`CHK(chip_locked, 1'b1)
		lk(`CBL_CMD_RD_FLASH, 15'h0123, 8'h00, 8'hFF);
		lk(`CBL_CMD_PR_FLASH, 15'h0042, 8'h3C, 8'h00);
		`CHK(wr_cnt[3:0], 4'h1)
		lk(`CBL_CMD_PR_OPT, 15'h0000, 8'hFF, 8'h00);
		lk(`CBL_CMD_RD_OPT, 15'h0000, 8'h00, 8'hE9);
		lk(`CBL_CMD_ERASE_ALL, 15'h0000, 8'h00, 8'h00);
		lk(`CBL_CMD_RD_OPT, 15'h0000, 8'h00, 8'hFF);
		`CHK({erase_cnt[3:0], chip_locked}, 5'h02)
		i_cbl_prog_model.set_mode(1'b0);
		repeat (8) @(posedge clk_sys);
		#1;
		`CHK(in_circuit_programming, 1'b0)
		$display("Test programming link done");
		tally_and_finish();
	end
endmodule // tb_top
